// >>> logic/fcw_top.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "fcw_consts.svh"
module fcw_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// command bit stream from the air-interface decoder
	input  wire logic        rx_start_i,
	input  wire logic        rx_bit_valid_i,
	input  wire logic        rx_bit_i,
	input  wire logic        rx_end_i,
	input  wire logic        frame_sync_i,
	// protocol core context
	input  wire logic [2:0]  tag_state_i,
	input  wire logic [15:0] rn16_i,
	input  wire logic        rn_valid_i,
	input  wire logic [15:0] handle_i,
	input  wire logic        access_pw_zero_i,
	input  wire logic        epc_locked_i,
	// command reply
	output logic             reply_valid_o,
	output logic [15:0]      reply_cfg_o,
	output logic [15:0]      reply_handle_o,
	output logic [15:0]      reply_crc_o,
	output logic             reply_ext_pre_o,
	output logic             go_arbitrate_o,
	// nonvolatile store of permanent bits
	output logic             nvm_wr_o,
	output logic [15:0]      nvm_data_o,
	input  wire logic        nvm_done_i,
	input  wire logic        nvm_load_i,
	input  wire logic [15:0] nvm_data_i,
	// standard write and legacy protect
	input  wire logic        wr_cfg_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        legacy_protect_i,
	// memory read filter
	input  wire logic        rd_valid_i,
	input  wire logic        rd_epc_i,
	input  wire logic        rd_tid_sn_i,
	input  wire logic [15:0] rd_word_i,
	output logic             rd_valid_o,
	output logic [15:0]      rd_word_o,
	// select matching
	input  wire logic        sel_valid_i,
	input  wire logic [15:0] sel_ptr_i,
	input  wire logic [4:0]  sel_len_i,
	input  wire logic [15:0] sel_mask_i,
	output logic             sel_valid_o,
	output logic             sel_match_o,
	// surveillance alarm
	input  wire logic        alarm_cmd_i,
	output logic             alarm_valid_o,
	output logic [63:0]      alarm_code_o,
	// feature controls
	output logic [15:0]      cfg_word_o,
	output logic             protect_epc_o,
	output logic             protect_tid_o,
	output logic             backscatter_max_o,
	output logic             range_reduction_flag_o,
	output logic             session_hold_o,
	// pads
	input  wire logic        demod_i,
	input  wire logic        tamper_pad_i,
	input  wire logic        field_enter_i,
	input  wire logic        vdd_pad_i,
	output logic             vdd_pad_o,
	output logic             vdd_pad_oe_n_o,
	output logic             out_pad_o
);
	fcw_pkg::fcw_state_s r_r;
	fcw_pkg::fcw_state_s r_nxt;

	logic [15:0] crc_w;
	logic        crc_clr;
	logic        crc_en;
	logic        crc_bit;
	logic [15:0] word_w;
	logic [15:0] tmask_w;
	logic [15:0] eff_w;
	logic [15:0] selm_w;
	logic        cmd_ok_w;

	////////////////////////////////////////////////////////////////////
	fcw_crc16 u_crc (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.clr_i     (crc_clr),
		.en_i      (crc_en),
		.bit_i     (crc_bit),
		.crc_o     (crc_w)
	);

	// one engine serves both directions; they never overlap in time
	// a start while busy must not wipe the reply checksum
	assign crc_clr = (rx_start_i && ((r_r.fsm == fcw_pkg::F_IDLE)
		|| (r_r.fsm == fcw_pkg::F_RX))) || (r_r.fsm == fcw_pkg::F_CHECK);
	assign crc_en  = ((r_r.fsm == fcw_pkg::F_RX) && rx_bit_valid_i)
		|| (r_r.fsm == fcw_pkg::F_TX);
	assign crc_bit = (r_r.fsm == fcw_pkg::F_TX) ? r_r.txsh[32] : rx_bit_i;

	assign word_w = {r_r.t2, r_r.v2, r_r.cfg[13:0]};
	assign tmask_w = r_r.rxsh[47:32] ^ rn16_i;
	assign cmd_ok_w = (r_r.rxsh[71:56] == `FCW_CMD_OPCODE)
		&& (r_r.rxsh[55:48] == `FCW_CMD_RFU)
		&& (r_r.rxcnt == `FCW_CMD_BITS) && !r_r.rxovf
		&& (crc_w == `FCW_CRC_RESID) && rn_valid_i;
	// open leaves word / zero password / secured applies
	assign eff_w = ((tag_state_i == fcw_pkg::TS_SECURED)
		|| ((tag_state_i == fcw_pkg::TS_OPEN) && access_pw_zero_i))
		? (tmask_w & `FCW_M_WR) : 16'h0000;
	assign selm_w = ~(16'hFFFF >> sel_len_i);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		r_nxt = r_r;
		r_nxt.rep_v  = 1'b0;
		r_nxt.arb    = 1'b0;
		r_nxt.nvm_wr = 1'b0;
		r_nxt.rd_v   = 1'b0;
		r_nxt.sel_v  = 1'b0;
		r_nxt.alm_v  = 1'b0;
		// pads pass two flops before use
		r_nxt.t1 = tamper_pad_i;
		r_nxt.t2 = r_r.t1;
		r_nxt.v1 = vdd_pad_i;
		r_nxt.v2 = r_r.v1;
		r_nxt.d1 = demod_i;
		r_nxt.d2 = r_r.d1;
		r_nxt.dem_d = r_r.d2;

		if (legacy_protect_i) begin
			r_nxt.cfg[`FCW_B_PEPC] = 1'b1;
			r_nxt.cfg[`FCW_B_PTID] = 1'b1;
		end
		// standard write only with unlocked bank
		if (wr_cfg_i && !epc_locked_i) begin
			r_nxt.cfg = (r_r.cfg & ~`FCW_M_WR) | (wr_data_i & `FCW_M_WR);
		end
		if (nvm_load_i) begin
			r_nxt.cfg = (r_nxt.cfg & ~`FCW_M_PERM)
				| (nvm_data_i & `FCW_M_PERM);
		end

		case (r_r.fsm)
			fcw_pkg::F_IDLE: begin
				if (rx_start_i) begin
					r_nxt.fsm   = fcw_pkg::F_RX;
					r_nxt.rxcnt = 7'h00;
					r_nxt.rxovf = 1'b0;
				end
			end
			fcw_pkg::F_RX: begin
				if (rx_start_i) begin
					r_nxt.rxcnt = 7'h00;
					r_nxt.rxovf = 1'b0;
				end else begin
					if (rx_bit_valid_i) begin
						r_nxt.rxsh = {r_r.rxsh[70:0], rx_bit_i};
						if (r_r.rxcnt == `FCW_CMD_BITS) begin
							r_nxt.rxovf = 1'b1;
						end else begin
							r_nxt.rxcnt = r_r.rxcnt + 7'h01;
						end
					end
					if (rx_end_i) begin
						r_nxt.fsm = fcw_pkg::F_CHECK;
					end
				end
			end
			fcw_pkg::F_CHECK: begin
				r_nxt.fsm = fcw_pkg::F_IDLE;
				if (cmd_ok_w) begin
					case (tag_state_i)
						fcw_pkg::TS_ARB, fcw_pkg::TS_REPLY,
						fcw_pkg::TS_ACK: begin
							r_nxt.arb = 1'b1;
						end
						fcw_pkg::TS_OPEN, fcw_pkg::TS_SECURED: begin
							if ((r_r.rxsh[31:16] == handle_i)
								&& ((tmask_w & `FCW_M_RFU) == 16'h0000)) begin
								r_nxt.cfg = r_nxt.cfg ^ eff_w;
								r_nxt.rep_cfg = {word_w[15:14],
									r_nxt.cfg[13:0]};
								r_nxt.rep_hdl = handle_i;
								r_nxt.txsh = {1'b0, word_w[15:14],
									r_nxt.cfg[13:0], handle_i};
								r_nxt.txcnt = 6'h00;
								if ((eff_w & `FCW_M_PERM) != 16'h0000) begin
									r_nxt.nvm_wr   = 1'b1;
									r_nxt.nvm_data = r_nxt.cfg & `FCW_M_PERM;
									r_nxt.fsm      = fcw_pkg::F_NVMW;
								end else begin
									r_nxt.fsm = fcw_pkg::F_TX;
								end
							end
						end
						default: begin
							r_nxt.fsm = fcw_pkg::F_IDLE;
						end
					endcase
				end
			end
			fcw_pkg::F_NVMW: begin
				if (nvm_done_i) begin
					r_nxt.fsm = fcw_pkg::F_TX;
				end
			end
			fcw_pkg::F_TX: begin
				r_nxt.txsh  = {r_r.txsh[31:0], 1'b0};
				r_nxt.txcnt = r_r.txcnt + 6'h01;
				if (r_r.txcnt == `FCW_TX_LAST) begin
					r_nxt.fsm = fcw_pkg::F_REPLY;
				end
			end
			fcw_pkg::F_REPLY: begin
				r_nxt.rep_v   = 1'b1;
				r_nxt.rep_crc = ~crc_w;
				r_nxt.fsm     = fcw_pkg::F_IDLE;
			end
			default: begin
				r_nxt.fsm = fcw_pkg::F_IDLE;
			end
		endcase

		r_nxt.rd_v = rd_valid_i;
		if ((rd_epc_i && r_r.cfg[`FCW_B_PEPC])
			|| (rd_tid_sn_i && r_r.cfg[`FCW_B_PTID])) begin
			r_nxt.rd_w = 16'h0000;
		end else begin
			r_nxt.rd_w = rd_word_i;
		end
		// select only at the config word address
		r_nxt.sel_v = sel_valid_i;
		r_nxt.sel_m = (sel_ptr_i == `FCW_CFG_ADDR)
			&& (((word_w ^ sel_mask_i) & selm_w) == 16'h0000);
		r_nxt.alm_v = alarm_cmd_i && r_r.cfg[`FCW_B_PSF];

		// data sub-mode toggles outside frame sync
		if (r_r.d2 && !r_r.dem_d && !frame_sync_i) begin
			r_nxt.tog = ~r_r.tog;
		end
		// transfer / raw / level / invert
		if (r_r.cfg[`FCW_B_XFER]) begin
			r_nxt.out = r_r.cfg[`FCW_B_RAW] ? r_r.d2 : r_r.tog;
		end else begin
			r_nxt.out = r_r.cfg[`FCW_B_DOUT] ^ r_r.cfg[`FCW_B_INVERT];
		end

		// field pulse on the sense pad
		if (field_enter_i) begin
			r_nxt.pcnt = 8'(`FCW_PULSE_CYC);
		end else if (r_r.pcnt != 8'h00) begin
			r_nxt.pcnt = r_r.pcnt - 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r_r <= '0;
			r_r.fsm <= fcw_pkg::F_IDLE;
			r_r.cfg <= `FCW_CFG_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign reply_valid_o   = r_r.rep_v;
	assign reply_cfg_o     = r_r.rep_cfg;
	assign reply_handle_o  = r_r.rep_hdl;
	assign reply_crc_o     = r_r.rep_crc;
	assign reply_ext_pre_o = r_r.rep_v;
	assign go_arbitrate_o  = r_r.arb;
	assign nvm_wr_o        = r_r.nvm_wr;
	assign nvm_data_o      = r_r.nvm_data;
	assign rd_valid_o      = r_r.rd_v;
	assign rd_word_o       = r_r.rd_w;
	assign sel_valid_o     = r_r.sel_v;
	assign sel_match_o     = r_r.sel_m;
	assign alarm_valid_o   = r_r.alm_v;
	assign alarm_code_o    = `FCW_ALARM_CODE;
	assign cfg_word_o      = word_w;
	assign protect_epc_o   = r_r.cfg[`FCW_B_PEPC];
	assign protect_tid_o   = r_r.cfg[`FCW_B_PTID];
	assign backscatter_max_o      = r_r.cfg[`FCW_B_BKS];
	assign range_reduction_flag_o = r_r.cfg[`FCW_B_RANGE];
	assign session_hold_o  = r_r.v2;
	assign vdd_pad_o       = 1'b1;
	assign vdd_pad_oe_n_o  = (r_r.pcnt == 8'h00);
	assign out_pad_o       = r_r.out;

	////////////////////////////////////////////////////////////////////
	AST_PROTECT_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(rd_valid_i && rd_epc_i && r_r.cfg[`FCW_B_PEPC])
		|-> (rd_word_o == 16'h0000))
		else $error("protected epc read not zero");

	AST_SEL_PTR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(sel_valid_i && (sel_ptr_i != `FCW_CFG_ADDR)) |-> !sel_match_o)
		else $error("select matched at wrong pointer");

	AST_LEGACY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(legacy_protect_i && !wr_cfg_i && !nvm_load_i
		&& r_r.fsm != fcw_pkg::F_CHECK) |-> (protect_epc_o && protect_tid_o))
		else $error("legacy protect did not set both flags");

	AST_ALARM: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(alarm_cmd_i) |-> (alarm_valid_o == $past(r_r.cfg[`FCW_B_PSF])))
		else $error("alarm reply does not follow status flag");

	AST_OUT_STATIC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(!r_r.cfg[`FCW_B_XFER]) |-> (out_pad_o
		== $past(r_r.cfg[`FCW_B_DOUT] ^ r_r.cfg[`FCW_B_INVERT])))
		else $error("static output level wrong");

	AST_EXT_MIRROR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cfg_word_o[`FCW_B_EXTSUP] == $past(vdd_pad_i, 2)))
		else $error("supply indicator not mirrored");

	AST_ARB: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(r_r.fsm == fcw_pkg::F_CHECK && cmd_ok_w
		&& tag_state_i == fcw_pkg::TS_ACK) |=> (go_arbitrate_o
		&& r_r.fsm == fcw_pkg::F_IDLE) ##1 !reply_valid_o [*8])
		else $error("acknowledged state did not drop to arbitrate");

	AST_OPEN_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(r_r.fsm == fcw_pkg::F_CHECK && tag_state_i == fcw_pkg::TS_OPEN
		&& !access_pw_zero_i && !wr_cfg_i && !legacy_protect_i && !nvm_load_i)
		|=> $stable(r_r.cfg))
		else $error("open state altered the word");

	AST_RFU_DROP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(r_r.fsm == fcw_pkg::F_CHECK && ((tmask_w & `FCW_M_RFU) != 16'h0000))
		|=> (r_r.fsm == fcw_pkg::F_IDLE) ##1 !reply_valid_o [*8])
		else $error("reserved toggle not discarded");

	AST_PULSE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		field_enter_i |=> !vdd_pad_oe_n_o [*8])
		else $error("field pulse missing");
endmodule

// >>> logic/fcw_consts.svh
// Behaviour
// - each payload one-bit inverts that config bit; repeating restores it. The code ignores one-bits at indicator bits 15 and 14.
// - reply is header 0, config word, handle, CRC-16.
// - ready or killed ignore; arbitrate, reply, ack go silently to arbitrate.
// - open state with valid handle reports word unchanged, stays open.
// - secured state applies change first, then reports the modified word.
// - no change needed: report present word at once, keep state.
// - protect flags zero EPC bank reads and TID serial reads separately.
// - select matches config bits only at pointer 200h.
// - legacy protect command sets both protection flags together.
// - product status flag set answers alarm command with 64-bit code.
// - backscatter flag defaults to maximum; clearing selects weaker level.
// - tamper pad state readable in config word, usable by select.
// - output pad follows stored output level, kept in nonvolatile memory.
// - invert bit flips output pad temporarily, stored level untouched.
// - transfer bit routes air interface to output pad.
// - data sub-mode drops frame sync, toggles pad per rising edge.
// - raw sub-mode copies demodulated signal onto output pad.
// - sense pad mirrored into supply bit; reader resets between polls.
// - under external supply S0, S2, S3, SL hold; S1 decays normally.
// - standard write changes feature bits only with unlocked EPC bank.
// - zero access password lets config bits toggle without authentication.
// - entering RF field emits a pulse on the supply-sense pad.
// - bad CRC or wrong handle discards command, state kept.
// - any toggle of a reserved bit discards the command.
// - successful reply always uses the extended preamble.
`ifndef FCW_CONSTS_SVH
`define FCW_CONSTS_SVH

`define FCW_CMD_OPCODE 16'hE007
`define FCW_CMD_RFU    8'h00
`define FCW_CMD_BITS   7'h48
`define FCW_CRC_PRESET 16'hFFFF
`define FCW_CRC_POLY   16'h1021
`define FCW_CRC_RESID  16'h1D0F
`define FCW_CFG_ADDR   16'h0200
`define FCW_CFG_RST    16'h0040
`define FCW_TX_LAST    6'h20

// config word bit positions, bit 15 sits at address 200h
`define FCW_B_TAMPER 15
`define FCW_B_EXTSUP 14
`define FCW_B_INVERT 11
`define FCW_B_XFER   10
`define FCW_B_RAW    9
`define FCW_B_BKS    6
`define FCW_B_DOUT   5
`define FCW_B_RANGE  4
`define FCW_B_PEPC   2
`define FCW_B_PTID   1
`define FCW_B_PSF    0

`define FCW_M_IND  16'hC000
`define FCW_M_RFU  16'h3188
`define FCW_M_WR   16'h0E77
`define FCW_M_PERM 16'h0077

`define FCW_CLK_NS   4
`define FCW_PULSE_NS 100
`define FCW_PULSE_CYC ((`FCW_PULSE_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
// arbitrary value, no meaning
`define FCW_ALARM_CODE 64'h0123456789ABCDEF

`endif

// >>> logic/fcw_pkg.sv
package fcw_pkg;
	typedef enum logic [2:0] {
		TS_READY   = 3'h0,
		TS_ARB     = 3'h1,
		TS_REPLY   = 3'h2,
		TS_ACK     = 3'h3,
		TS_OPEN    = 3'h4,
		TS_SECURED = 3'h5,
		TS_KILLED  = 3'h6
	} fcw_tag_state_e;

	typedef enum logic [2:0] {
		F_IDLE  = 3'h0,
		F_RX    = 3'h1,
		F_CHECK = 3'h2,
		F_NVMW  = 3'h3,
		F_TX    = 3'h4,
		F_REPLY = 3'h5
	} fcw_fsm_e;

	typedef struct packed {
		logic [15:0] crc;
	} fcw_crc_s;

	typedef struct packed {
		fcw_fsm_e    fsm;
		logic [71:0] rxsh;
		logic [6:0]  rxcnt;
		logic        rxovf;
		logic [15:0] cfg;
		logic [32:0] txsh;
		logic [5:0]  txcnt;
		logic        rep_v;
		logic [15:0] rep_cfg;
		logic [15:0] rep_hdl;
		logic [15:0] rep_crc;
		logic        arb;
		logic        nvm_wr;
		logic [15:0] nvm_data;
		logic        rd_v;
		logic [15:0] rd_w;
		logic        sel_v;
		logic        sel_m;
		logic        alm_v;
		logic        tog;
		logic        dem_d;
		logic        out;
		logic        t1;
		logic        t2;
		logic        v1;
		logic        v2;
		logic        d1;
		logic        d2;
		logic [7:0]  pcnt;
	} fcw_state_s;
endpackage

// >>> logic/fcw_crc16.sv
`timescale 1ns/1ps
`include "fcw_consts.svh"
module fcw_crc16 (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// bit stream
	input  wire logic        clr_i,
	input  wire logic        en_i,
	input  wire logic        bit_i,
	// running remainder
	output logic [15:0]      crc_o
);
	fcw_pkg::fcw_crc_s r_r;
	fcw_pkg::fcw_crc_s r_nxt;

	always_comb begin
		r_nxt = r_r;
		if (clr_i) begin
			r_nxt.crc = `FCW_CRC_PRESET;
		end else if (en_i) begin
			r_nxt.crc = {r_r.crc[14:0], 1'b0};
			if (r_r.crc[15] ^ bit_i) begin
				r_nxt.crc = r_nxt.crc ^ `FCW_CRC_POLY;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r_r.crc <= `FCW_CRC_PRESET;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign crc_o = r_r.crc;
endmodule

// >>> tb/fcw_reader_model.sv
`timescale 1ns/1ps
`include "fcw_consts.svh"
module fcw_reader_model (
	// clock
	input  wire logic clk_i,
	// command stream towards the tag
	output logic      rx_start_o,
	output logic      rx_bit_valid_o,
	output logic      rx_bit_o,
	output logic      rx_end_o,
	output logic      frame_sync_o
);
	initial begin
		{rx_start_o, rx_bit_valid_o, rx_bit_o, rx_end_o, frame_sync_o} = '0;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc16(input logic [71:0] v, input int n);
		logic [15:0] c;
		c = `FCW_CRC_PRESET;
		for (int i = n - 1; i >= 0; i--)
			c = {c[14:0], 1'h0} ^ ((c[15] ^ v[i]) ? `FCW_CRC_POLY : 16'h0000);
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// command frame layout
	task automatic send(input logic [15:0] m, rn, hdl, input logic bad);
		logic [71:0] f;
		f[71:16] = {`FCW_CMD_OPCODE, `FCW_CMD_RFU, m ^ rn, hdl};
		// bad flips one bit so the tag must see a broken checksum
		f[15:0] = ~crc16({16'h0000, f[71:16]}, 56) ^ {15'h0000, bad};
		rx_start_o <= 1'h1;
		frame_sync_o <= 1'h1;
		for (int i = 71; i >= 0; i--) begin
			@(posedge clk_i);
			rx_start_o <= 1'h0;
			rx_bit_valid_o <= 1'h1;
			rx_bit_o <= f[i];
			rx_end_o <= (i == 0);
		end
		@(posedge clk_i);
		rx_bit_valid_o <= 1'h0;
		rx_end_o <= 1'h0;
		frame_sync_o <= 1'h0;
		// released line shows the inverse, never a stale bit
		rx_bit_o <= ~f[0];
	endtask
endmodule

// >>> tb/fcw_top_bench.sv
`timescale 1ns/1ps
`include "fcw_consts.svh"
module fcw_top_bench;
	logic        clk_i, sys_rst_i, rx_start_i, rx_bit_valid_i, rx_bit_i;
	logic        rx_end_i, frame_sync_i, rn_valid_i, access_pw_zero_i;
	logic        epc_locked_i, nvm_done_i, nvm_load_i, wr_cfg_i, vdd_ext;
	logic        legacy_protect_i, rd_valid_i, rd_epc_i, rd_tid_sn_i;
	logic        sel_valid_i, alarm_cmd_i, demod_i, tamper_pad_i;
	logic        field_enter_i, vdd_pad_i, arb;
	logic [2:0]  tag_state_i;
	logic [4:0]  sel_len_i;
	logic [15:0] rn16_i, handle_i, nvm_data_i, wr_data_i, rd_word_i;
	logic [15:0] sel_ptr_i, sel_mask_i, cw, nvm_q;
	logic        reply_valid_o, reply_ext_pre_o, go_arbitrate_o, nvm_wr_o;
	logic        rd_valid_o, sel_valid_o, sel_match_o, alarm_valid_o;
	logic        protect_epc_o, protect_tid_o, backscatter_max_o;
	logic        range_reduction_flag_o, session_hold_o, vdd_pad_o;
	logic        vdd_pad_oe_n_o, out_pad_o;
	logic [15:0] reply_cfg_o, reply_handle_o, reply_crc_o, nvm_data_o;
	logic [15:0] cfg_word_o, rd_word_o;
	logic [63:0] alarm_code_o;
	int          err_count, n_compared, i;
	int          nvm_n = 0;

	fcw_top fcw_top_inst (
		.clk_i, .sys_rst_i, .rx_start_i, .rx_bit_valid_i, .rx_bit_i,
		.rx_end_i, .frame_sync_i, .tag_state_i, .rn16_i, .rn_valid_i,
		.handle_i, .access_pw_zero_i, .epc_locked_i, .reply_valid_o,
		.reply_cfg_o, .reply_handle_o, .reply_crc_o, .reply_ext_pre_o,
		.go_arbitrate_o, .nvm_wr_o, .nvm_data_o, .nvm_done_i, .nvm_load_i,
		.nvm_data_i, .wr_cfg_i, .wr_data_i, .legacy_protect_i, .rd_valid_i,
		.rd_epc_i, .rd_tid_sn_i, .rd_word_i, .rd_valid_o, .rd_word_o,
		.sel_valid_i, .sel_ptr_i, .sel_len_i, .sel_mask_i, .sel_valid_o,
		.sel_match_o, .alarm_cmd_i, .alarm_valid_o, .alarm_code_o,
		.cfg_word_o, .protect_epc_o, .protect_tid_o, .backscatter_max_o,
		.range_reduction_flag_o, .session_hold_o, .demod_i, .tamper_pad_i,
		.field_enter_i, .vdd_pad_i, .vdd_pad_o, .vdd_pad_oe_n_o, .out_pad_o
	);
	fcw_reader_model fcw_reader_model_inst (
		.clk_i,
		.rx_start_o     (rx_start_i),
		.rx_bit_valid_o (rx_bit_valid_i),
		.rx_bit_o       (rx_bit_i),
		.rx_end_o       (rx_end_i),
		.frame_sync_o   (frame_sync_i)
	);

	// pad level: tag drive wins while enabled, else the outside source
	assign vdd_pad_i = vdd_pad_oe_n_o ? vdd_ext : vdd_pad_o;
	always #2 clk_i = ~clk_i;

	// store finishes one cycle after each write request
	always @(posedge clk_i) begin
		nvm_done_i <= (nvm_wr_o === 1'h1);
		if (nvm_wr_o === 1'h1) begin
			nvm_n <= nvm_n + 1;
			nvm_q <= nvm_data_o;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmd(input logic [2:0] st, input logic [15:0] m,
	                   input logic bad, input logic [15:0] h, input logic ok);
		logic        seen;
		logic [15:0] rc;
		seen = 1'h0;
		arb = 1'h0;
		rc = ~fcw_reader_model_inst.crc16({40'h0, cw, handle_i}, 33);
		tag_state_i <= st;
		fcw_reader_model_inst.send(m, rn16_i, h, bad);
		repeat (300) begin // bounded wait
			@(posedge clk_i);
			arb |= (go_arbitrate_o === 1'h1);
			if (reply_valid_o === 1'h1) begin
				seen = 1'h1;
				chk(reply_cfg_o, cw); // word field
				chk(reply_handle_o, handle_i); // handle field
				chk(reply_crc_o, rc); // reply checksum
				chk(reply_ext_pre_o, 1'h1); // long preamble
			end
		end
		chk(seen, ok); // reply presence
	endtask

	task automatic alarm(input logic x);
		alarm_cmd_i <= 1'h1;
		step(1);
		alarm_cmd_i <= 1'h0;
		step(1);
		chk(alarm_valid_o, x); // alarm answer
		if (x)
			chk(alarm_code_o, `FCW_ALARM_CODE); // alarm code
	endtask

	task automatic rd(input logic e, t, input logic [15:0] w, x);
		rd_valid_i <= 1'h1;
		rd_epc_i <= e;
		rd_tid_sn_i <= t;
		rd_word_i <= w;
		step(1);
		rd_valid_i <= 1'h0;
		step(1);
		chk(rd_valid_o, 1'h1); // read passes
		chk(rd_word_o, x); // filtered word
	endtask

	task automatic sel(input logic [15:0] p, m, input logic [4:0] n,
	                   input logic x);
		sel_valid_i <= 1'h1;
		sel_ptr_i <= p;
		sel_len_i <= n;
		sel_mask_i <= m;
		step(1);
		sel_valid_i <= 1'h0;
		step(1);
		chk(sel_valid_o, 1'h1); // select answer
		chk(sel_match_o, x); // select result
	endtask

	task automatic wr_cfg(input logic [15:0] d);
		wr_data_i <= d;
		wr_cfg_i <= 1'h1;
		step(1);
		wr_cfg_i <= 1'h0;
		step(4);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'h0;
		sys_rst_i = 1'h1;
		{access_pw_zero_i, nvm_load_i, wr_cfg_i, legacy_protect_i, rd_valid_i,
		 rd_epc_i, rd_tid_sn_i, sel_valid_i, alarm_cmd_i, demod_i, vdd_ext,
		 tamper_pad_i, field_enter_i, tag_state_i, sel_len_i, nvm_data_i,
		 wr_data_i, rd_word_i, sel_ptr_i, sel_mask_i} = '0;
		rn_valid_i = 1'h1;
		epc_locked_i = 1'h1;
		rn16_i = 16'hC3A5;
		handle_i = 16'h5A3C;
		err_count = 0;
		n_compared = 0;
		step(10);
		sys_rst_i <= 1'h0;
		step(1);
		cw = `FCW_CFG_RST;
		chk(cfg_word_o, cw); // reset word
		chk(backscatter_max_o, 1'h1); // strong level
		cw = cw ^ 16'h0011;
		cmd(3'h5, 16'h0011, 1'h0, handle_i, 1'h1); // secured toggle
		chk(nvm_q, cw & `FCW_M_PERM); // stored bits
		chk(range_reduction_flag_o, 1'h1); // flag set
		alarm(1'h1); // flag set
		cw = cw ^ 16'h0011;
		cmd(3'h5, 16'h0011, 1'h0, handle_i, 1'h1); // repeat restores
		alarm(1'h0); // flag clear
		cmd(3'h4, 16'h0002, 1'h0, handle_i, 1'h1); // open unchanged
		access_pw_zero_i <= 1'h1;
		cw = cw ^ 16'h0002;
		cmd(3'h4, 16'h0002, 1'h0, handle_i, 1'h1); // zero password
		rd(1'h0, 1'h1, 16'hBEEF, 16'h0000); // serial hidden
		rd(1'h1, 1'h0, 16'hBEEF, 16'hBEEF); // own flag only
		access_pw_zero_i <= 1'h0;
		i = nvm_n;
		cmd(3'h5, 16'h0000, 1'h0, handle_i, 1'h1); // no change
		chk(nvm_n, i); // nothing stored
		for (i = 0; i < 6; i++) begin
			rn_valid_i <= (i != 5);
			cmd(i == 0 ? 3'h0 : i == 1 ? 3'h6 : 3'h5,
			    i == 4 ? 16'h0008 : 16'h0002, i == 2,
			    i == 3 ? ~handle_i : handle_i, 1'h0); // discarded
			chk(arb, 1'h0); // state kept
		end
		rn_valid_i <= 1'h1;
		for (i = 1; i < 4; i++) begin
			cmd(i[2:0], 16'h0002, 1'h0, handle_i, 1'h0); // silent
			chk(arb, 1'h1); // back to arbitrate
		end
		chk(protect_tid_o, 1'h1); // word kept
		i = nvm_n;
		cw = cw ^ 16'h0800;
		cmd(3'h5, 16'h0800, 1'h0, handle_i, 1'h1); // temporary bit
		chk(nvm_n, i); // level not stored
		chk(out_pad_o, 1'h1); // pad inverted
		cw = cw ^ 16'h0800;
		cmd(3'h5, 16'h0800, 1'h0, handle_i, 1'h1); // invert off
		chk(out_pad_o, 1'h0); // stored low
		legacy_protect_i <= 1'h1;
		step(1);
		legacy_protect_i <= 1'h0;
		step(1);
		cw = cw | 16'h0006;
		chk(cfg_word_o, cw); // both flags
		chk(protect_epc_o, 1'h1); // epc flag
		rd(1'h1, 1'h0, 16'hBEEF, 16'h0000); // bank hidden
		rd(1'h0, 1'h0, 16'h1234, 16'h1234); // other words
		sel(16'h0200, cw, 5'h10, 1'h1); // word pointer
		sel(16'h0201, cw, 5'h10, 1'h0); // other pointer
		sel(16'h0200, ~cw, 5'h10, 1'h0); // mask differs
		wr_cfg(cw | 16'h0020);
		chk(out_pad_o, 1'h0); // locked bank
		epc_locked_i <= 1'h0;
		wr_cfg(cw | 16'h0020);
		cw = cw | 16'h0020;
		chk(cfg_word_o, cw); // unlocked write
		chk(out_pad_o, 1'h1); // pad high
		nvm_data_i <= 16'hFF88;
		nvm_load_i <= 1'h1;
		step(1);
		nvm_load_i <= 1'h0;
		step(1);
		cw = cw & ~`FCW_M_PERM;
		chk(cfg_word_o, cw); // stored bits reload
		chk(backscatter_max_o, 1'h0); // weaker level
		cw = cw ^ 16'h0600;
		cmd(3'h5, 16'h0600, 1'h0, handle_i, 1'h1); // transfer on
		step(4);
		chk(out_pad_o, 1'h0); // raw copy low
		demod_i <= 1'h1;
		step(4);
		chk(out_pad_o, 1'h1); // raw copy high
		cw = cw ^ 16'h0200;
		cmd(3'h5, 16'h0200, 1'h0, handle_i, 1'h1); // data mode
		demod_i <= 1'h0;
		step(4);
		arb = out_pad_o;
		demod_i <= 1'h1;
		step(5);
		chk(out_pad_o, !arb); // toggle on rise
		tamper_pad_i <= 1'h1;
		vdd_ext <= 1'h1;
		step(4);
		chk(cfg_word_o[15:14], 2'h3); // indicators
		chk(session_hold_o, 1'h1); // sessions held
		sel(16'h0200, 16'h8000, 5'h01, 1'h1); // tamper select
		field_enter_i <= 1'h1;
		step(1);
		field_enter_i <= 1'h0;
		step(1);
		chk(vdd_pad_oe_n_o, 1'h0); // pulse starts
		chk(vdd_pad_o, 1'h1); // pad driven high
		step(`FCW_PULSE_CYC - 1);
		chk(vdd_pad_oe_n_o, 1'h0); // pulse width
		step(1);
		chk(vdd_pad_oe_n_o, 1'h1); // pulse ends
		tally_and_finish();
	end

	initial begin
		step(30000);
		err_count++;
		tally_and_finish();
	end
endmodule
